// ===== loop_watchdog_interval_timer_tb_top.sv
// Self-checking bench joining the CPU end and the timer end
`timescale 1ns/1ps
`default_nettype none
`include "lwit_defs.svh"
module loop_watchdog_interval_timer_tb_top;
	import lwit_pkg::*;
	logic        clk_sys_in = 0, rst_n_in = 0, req_wr_in = 0, req_rd_in = 0, stop_release_in = 0;
	logic        sub_clk_sel_in = 0, rsp_valid_out, nmi_out, tick_out, settle_busy_out;
	logic [31:0] req_addr_in = 0;
	logic [7:0]  req_wdata_in = 0, rsp_data_out;
	logic [2:0]  settle_code_out;
	lwit_pwr_t   pwr_in = LWIT_PWR_RUN;
	int          bad_count = 0, total_checks = 0, cyc = 0, i, tick_n = 0, nmi_n = 0;
	int          tick_at = 0, nmi_at = 0, tick_gap = 0, nmi_gap = 0;
	lwit_bus_if lwit_bus_if_inst ();
	lwit_timer lwit_timer_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus(lwit_bus_if_inst),
		.stop_release_in(stop_release_in), .settle_busy_out(settle_busy_out), .settle_code_out(settle_code_out));
	lwit_cpu_port lwit_cpu_port_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bus(lwit_bus_if_inst),
		.req_wr_in(req_wr_in), .req_rd_in(req_rd_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.pwr_in(pwr_in), .sub_clk_sel_in(sub_clk_sel_in), .rsp_data_out(rsp_data_out),
		.rsp_valid_out(rsp_valid_out), .nmi_out(nmi_out), .tick_out(tick_out));
	lwit_monitor lwit_monitor_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr(lwit_bus_if_inst.addr),
		.wr(lwit_bus_if_inst.wr), .rd(lwit_bus_if_inst.rd), .wdata(lwit_bus_if_inst.wdata),
		.rdata(lwit_bus_if_inst.rdata), .rvalid(lwit_bus_if_inst.rvalid), .pwr(lwit_bus_if_inst.pwr),
		.sub_clk_sel(lwit_bus_if_inst.sub_clk_sel), .nmi(lwit_bus_if_inst.nmi), .tick(lwit_bus_if_inst.tick));
	always #5 clk_sys_in = ~clk_sys_in;
	// Spacing of interrupt pulses, in clock cycles
	always @(posedge clk_sys_in) begin
		cyc++;
		if (tick_out === 1'b1) begin
			tick_gap = cyc - tick_at;
			tick_at = cyc;
			tick_n++;
		end
		if (nmi_out === 1'b1) begin
			nmi_gap = cyc - nmi_at;
			nmi_at = cyc;
			nmi_n++;
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		req_wr_in = 1;
		req_addr_in = a;
		req_wdata_in = d;
		@(negedge clk_sys_in);
		req_wr_in = 0;
		repeat (2) @(negedge clk_sys_in);
	endtask : wr_reg
	task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
		@(negedge clk_sys_in);
		req_rd_in = 1;
		req_addr_in = a;
		@(negedge clk_sys_in);
		req_rd_in = 0;
		for (int k = 0; k < 8 && rsp_valid_out !== 1'b1; k++) @(negedge clk_sys_in);
		chk("read data", rsp_data_out, exp);
	endtask : rd_chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// Cuts a hang short; the planned run is near 93000 cycles
	initial begin
		repeat (99000) @(posedge clk_sys_in);
		bad_count++;
		report_and_stop;
	end
	// Register map, settle wait, interval period with stalls, then guard mode
	initial begin
		repeat (8) @(negedge clk_sys_in);
		rst_n_in = 1;
		chk("settle busy", settle_busy_out, 1);
		chk("settle code", settle_code_out, 4);
		rd_chk(`LWIT_ADDR_SETTLE, 8'h04);
		rd_chk(`LWIT_ADDR_PERIOD, 8'h00);
		rd_chk(`LWIT_ADDR_MODE, 8'h00);
		rd_chk(32'hFFFFF386, 8'h00);
		for (i = 7; i >= 0; i--) begin
			wr_reg(`LWIT_ADDR_PERIOD, 8'hF8 | i[7:0]);
			rd_chk(`LWIT_ADDR_PERIOD, i[7:0]);
		end
		wr_reg(`LWIT_ADDR_SETTLE, 8'hFB);
		rd_chk(`LWIT_ADDR_SETTLE, 8'h03);
		chk("settle code", settle_code_out, 3);
		wr_reg(`LWIT_ADDR_SETTLE, 8'h00);
		@(negedge clk_sys_in);
		stop_release_in = 1;
		@(negedge clk_sys_in);
		stop_release_in = 0;
		for (i = 1; i < 17000 && settle_busy_out === 1'b1; i++) @(negedge clk_sys_in);
		// 2^14 wait, plus the edge that takes the release and the output register stage
		chk("settle cycles", i, 16384 + 2);
		wr_reg(`LWIT_ADDR_MODE, 8'h80);
		for (i = 0; i < 17000 && tick_n < 1; i++) @(negedge clk_sys_in);
		// Stalled cycles must add to the gap exactly, as the count is held
		pwr_in = LWIT_PWR_IDLE;
		repeat (1000) @(negedge clk_sys_in);
		pwr_in = LWIT_PWR_STOP;
		repeat (1000) @(negedge clk_sys_in);
		pwr_in = LWIT_PWR_HALT;
		sub_clk_sel_in = 1;
		repeat (1000) @(negedge clk_sys_in);
		sub_clk_sel_in = 0;
		for (i = 0; i < 17000 && tick_n < 2; i++) @(negedge clk_sys_in);
		chk("tick gap", tick_gap, 16384 + 3000);
		wr_reg(`LWIT_ADDR_MODE, 8'h90);
		wr_reg(`LWIT_ADDR_MODE, 8'h00);
		rd_chk(`LWIT_ADDR_MODE, 8'h90);
		repeat (8000) @(negedge clk_sys_in);
		wr_reg(`LWIT_ADDR_MODE, 8'h90);
		repeat (8000) @(negedge clk_sys_in);
		chk("early nmi", nmi_n, 0);
		for (i = 0; i < 40000 && nmi_n < 2; i++) @(negedge clk_sys_in);
		chk("nmi gap", nmi_gap, 16384);
		chk("guard ticks", tick_n, 2);
		report_and_stop;
	end
endmodule : loop_watchdog_interval_timer_tb_top
`default_nettype wire

// ===== lwit_bus_if.sv
// Internal bus carrier between CPU-side master and the timer
`timescale 1ns/1ps
`default_nettype none
interface lwit_bus_if;
	import lwit_pkg::*;
	logic [31:0] addr;
	logic        wr;
	logic        rd;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        rvalid;
	lwit_pwr_t   pwr;
	logic        sub_clk_sel;
	logic        nmi;
	logic        tick;
	modport dev (input addr, wr, rd, wdata, pwr, sub_clk_sel, output rdata, rvalid, nmi, tick);
	modport cpu (output addr, wr, rd, wdata, pwr, sub_clk_sel, input rdata, rvalid, nmi, tick);
endinterface : lwit_bus_if
`default_nettype wire

// ===== lwit_cpu_port.sv
// CPU end: turns user register requests into bus cycles and collects interrupts
`timescale 1ns/1ps
`default_nettype none
`include "lwit_defs.svh"
module lwit_cpu_port (
	input  wire logic               clk_sys_in,
	input  wire logic               rst_n_in,
	lwit_bus_if.cpu                 bus,
	input  wire logic               req_wr_in,
	input  wire logic               req_rd_in,
	input  wire logic [31:0]        req_addr_in,
	input  wire logic [7:0]         req_wdata_in,
	input  wire lwit_pkg::lwit_pwr_t pwr_in,
	input  wire logic               sub_clk_sel_in,
	output logic [7:0]              rsp_data_out,
	output logic                    rsp_valid_out,
	output logic                    nmi_out,
	output logic                    tick_out
);
	import lwit_pkg::*;

	// Drive one byte cycle per request; period and settle writes mask bits 3-7 to zero
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			bus.addr  <= 32'h00000000;
			bus.wr    <= 1'b0;
			bus.rd    <= 1'b0;
			bus.wdata <= 8'h00;
		end else begin
			bus.addr <= req_addr_in;
			bus.wr   <= req_wr_in;
			bus.rd   <= req_rd_in && !req_wr_in;
			if (req_addr_in == `LWIT_ADDR_PERIOD || req_addr_in == `LWIT_ADDR_SETTLE) begin
				bus.wdata <= {5'h00, req_wdata_in[2:0]};
			end else begin
				bus.wdata <= req_wdata_in;
			end
		end
	end

	// Power state and clock source forwarded to the timer
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			bus.pwr         <= LWIT_PWR_RUN;
			bus.sub_clk_sel <= 1'b0;
		end else begin
			bus.pwr         <= pwr_in;
			bus.sub_clk_sel <= sub_clk_sel_in;
		end
	end

	// Responses and interrupt pulses, registered
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rsp_data_out  <= 8'h00;
			rsp_valid_out <= 1'b0;
			nmi_out       <= 1'b0;
			tick_out      <= 1'b0;
		end else begin
			rsp_data_out  <= bus.rdata;
			rsp_valid_out <= bus.rvalid;
			nmi_out       <= bus.nmi;
			tick_out      <= bus.tick;
		end
	end
endmodule : lwit_cpu_port
`default_nettype wire

// ===== lwit_defs.svh
// Register offsets, field positions, reset values and timing constants of the loop watchdog / interval timer
`ifndef LWIT_DEFS_SVH
`define LWIT_DEFS_SVH
`define LWIT_ADDR_SETTLE      32'hFFFFF380
`define LWIT_ADDR_PERIOD      32'hFFFFF382
`define LWIT_ADDR_MODE        32'hFFFFF384
`define LWIT_RST_SETTLE       8'h04
`define LWIT_RST_PERIOD       8'h00
`define LWIT_RST_MODE         8'h00
`define LWIT_CODE_MSB         2
`define LWIT_MODE_RUN_BIT     7
`define LWIT_MODE_GUARD_BIT   4
`define LWIT_CNT_W            22
`define LWIT_LAST_P14         22'h003FFF
`define LWIT_LAST_P15         22'h007FFF
`define LWIT_LAST_P16         22'h00FFFF
`define LWIT_LAST_P17         22'h01FFFF
`define LWIT_LAST_P18         22'h03FFFF
`define LWIT_LAST_P19         22'h07FFFF
`define LWIT_LAST_P20         22'h0FFFFF
`define LWIT_LAST_P22         22'h3FFFFF
`define LWIT_PRE_W            10
`define LWIT_STOP_PENDING_W   1
`endif

// ===== lwit_monitor.sv
// Checker on the bus joining the CPU end and the timer end
`timescale 1ns/1ps
`default_nettype none
`include "lwit_defs.svh"
module lwit_monitor import lwit_pkg::*; (
	input wire logic        clk_sys_in,
	input wire logic        rst_n_in,
	input wire logic [31:0] addr,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  wdata,
	input wire logic [7:0]  rdata,
	input wire logic        rvalid,
	input wire lwit_pwr_t   pwr,
	input wire logic        sub_clk_sel,
	input wire logic        nmi,
	input wire logic        tick
);
	logic guard_ff;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Guard selection is sticky, so the tracker only ever sets
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			guard_ff <= 1'b0;
		else if (wr && addr == `LWIT_ADDR_MODE && wdata[`LWIT_MODE_GUARD_BIT])
			guard_ff <= 1'b1;
	end
	sequence s_rd; rd && !wr; endsequence
	sequence s_halt; (pwr inside {LWIT_PWR_IDLE, LWIT_PWR_STOP} || sub_clk_sel) [*3]; endsequence
	property p_rd_ans; s_rd |=> rvalid; endproperty
	property p_rv_cause; rvalid |-> $past(rd && !wr); endproperty
	property p_unmapped; rvalid && !($past(addr) inside {`LWIT_ADDR_SETTLE, `LWIT_ADDR_PERIOD, `LWIT_ADDR_MODE})
		|-> rdata == 8'h00; endproperty
	property p_code_bits; rvalid && $past(addr) inside {`LWIT_ADDR_SETTLE, `LWIT_ADDR_PERIOD}
		|-> rdata[7:3] == 5'h00; endproperty
	property p_mode_bits; rvalid && $past(addr) == `LWIT_ADDR_MODE |-> rdata[6:5] == 2'h0 && rdata[3:0] == 4'h0;
	endproperty
	property p_nmi_guard; nmi |-> guard_ff; endproperty
	property p_no_tick; $past(guard_ff, 2) |-> !tick; endproperty
	property p_halted; s_halt |-> !tick && !nmi; endproperty
	property p_spacing; tick || nmi |=> !(tick || nmi) [*8]; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_code_bits: assert property (p_code_bits) else $error("upper code bits set");
	a_mode_bits: assert property (p_mode_bits) else $error("mode filler bits set");
	a_nmi_guard: assert property (p_nmi_guard) else $error("nmi outside guard mode");
	a_no_tick: assert property (p_no_tick) else $error("tick in guard mode");
	a_halted: assert property (p_halted) else $error("interrupt while stopped");
	a_spacing: assert property (p_spacing) else $error("interrupts too close");
endmodule : lwit_monitor
`default_nettype wire

// ===== lwit_pkg.sv
// Types shared by the two ends of the loop watchdog / interval timer
package lwit_pkg;
	typedef enum logic [1:0] {LWIT_PWR_RUN, LWIT_PWR_HALT, LWIT_PWR_IDLE, LWIT_PWR_STOP} lwit_pwr_t;
	typedef enum logic {LWIT_MODE_INTERVAL, LWIT_MODE_GUARD} lwit_mode_t;
endpackage : lwit_pkg

// ===== lwit_timer.sv
// Device end: loop watchdog / interval timer with settle-time register
`timescale 1ns/1ps
`default_nettype none
`include "lwit_defs.svh"
module lwit_timer (
	input  wire logic          clk_sys_in,
	input  wire logic          rst_n_in,
	lwit_bus_if.dev            bus,
	input  wire logic          stop_release_in,
	output logic               settle_busy_out,
	output logic [2:0]         settle_code_out
);
	import lwit_pkg::*;

	logic [2:0]                 settle_code_ff;
	logic [2:0]                 period_code_ff;
	logic                       run_ff;
	lwit_mode_t                 mode_ff;
	logic [`LWIT_CNT_W-1:0]     cnt_ff;
	logic [`LWIT_CNT_W-1:0]     nxt_cnt;
	logic [`LWIT_CNT_W-1:0]     settle_cnt_ff;
	logic [`LWIT_CNT_W-1:0]     period_last;
	logic [`LWIT_CNT_W-1:0]     settle_last;
	logic                       count_en;
	logic                       overflow;
	logic                       wr_settle;
	logic                       wr_period;
	logic                       wr_mode;
	logic                       restart;
	logic [7:0]                 nxt_rdata;
	logic                       settling_ff;

	// Byte-wide decode; the bus carries only 8-bit data so every write is a byte write
	assign wr_settle = bus.wr && (bus.addr == `LWIT_ADDR_SETTLE);
	assign wr_period = bus.wr && (bus.addr == `LWIT_ADDR_PERIOD);
	assign wr_mode   = bus.wr && (bus.addr == `LWIT_ADDR_MODE);
	assign restart   = wr_mode && bus.wdata[`LWIT_MODE_RUN_BIT];

	// Settle code register; upper bits not stored
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			settle_code_ff <= 3'(`LWIT_RST_SETTLE);
		end else if (wr_settle) begin
			settle_code_ff <= bus.wdata[`LWIT_CODE_MSB:0];
		end
	end

	// Period code register; bits 3-7 are dropped so a careless write cannot break the selector
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			period_code_ff <= 3'(`LWIT_RST_PERIOD);
		end else if (wr_period) begin
			period_code_ff <= bus.wdata[`LWIT_CODE_MSB:0];
		end
	end

	// Run and mode bits only ever set by software
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			run_ff  <= 1'b0;
			mode_ff <= LWIT_MODE_INTERVAL;
		end else if (wr_mode) begin
			run_ff <= run_ff | bus.wdata[`LWIT_MODE_RUN_BIT];
			if (bus.wdata[`LWIT_MODE_GUARD_BIT]) begin
				mode_ff <= LWIT_MODE_GUARD;
			end
		end
	end

	// Terminal count for the selected power of two
	always_comb begin
		unique case (period_code_ff)
			3'h0: period_last = `LWIT_LAST_P14;
			3'h1: period_last = `LWIT_LAST_P15;
			3'h2: period_last = `LWIT_LAST_P16;
			3'h3: period_last = `LWIT_LAST_P17;
			3'h4: period_last = `LWIT_LAST_P18;
			3'h5: period_last = `LWIT_LAST_P19;
			3'h6: period_last = `LWIT_LAST_P20;
			3'h7: period_last = `LWIT_LAST_P22;
		endcase
	end

	// Settle wait terminal count; prohibited codes fall back to the longest wait for safety
	always_comb begin
		unique case (settle_code_ff)
			3'h0:    settle_last = `LWIT_LAST_P14;
			3'h1:    settle_last = `LWIT_LAST_P16;
			3'h2:    settle_last = `LWIT_LAST_P17;
			3'h3:    settle_last = `LWIT_LAST_P18;
			default: settle_last = `LWIT_LAST_P19;
		endcase
	end

	// Counter freezes in IDLE, STOP and while the CPU runs on the subclock
	assign count_en = run_ff && !bus.sub_clk_sel
		&& (bus.pwr == LWIT_PWR_RUN || bus.pwr == LWIT_PWR_HALT);
	assign overflow = count_en && (cnt_ff == period_last);

	// Binary up-counter on the main clock; a restart clears it
	always_comb begin
		nxt_cnt = cnt_ff;
		if (restart) begin
			nxt_cnt = '0;
		end else if (overflow) begin
			nxt_cnt = '0;
		end else if (count_en) begin
			nxt_cnt = cnt_ff + 22'h000001;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Overflow routed by mode: NMI for loop guard, IRQ for interval; no reset is ever raised
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			bus.nmi  <= 1'b0;
			bus.tick <= 1'b0;
		end else begin
			bus.nmi  <= overflow && !restart && (mode_ff == LWIT_MODE_GUARD);
			bus.tick <= overflow && !restart && (mode_ff == LWIT_MODE_INTERVAL);
		end
	end

	// Oscillator settle wait: starts at reset release and on each STOP release
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			settling_ff   <= 1'b1;
			settle_cnt_ff <= '0;
		end else if (stop_release_in) begin
			settling_ff   <= 1'b1;
			settle_cnt_ff <= '0;
		end else if (settling_ff) begin
			if (settle_cnt_ff == settle_last) begin
				settling_ff <= 1'b0;
			end
			settle_cnt_ff <= settle_cnt_ff + 22'h000001;
		end
	end

	// Read data registered; reserved bits read zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (bus.addr == `LWIT_ADDR_SETTLE) begin
			nxt_rdata = {5'h00, settle_code_ff};
		end else if (bus.addr == `LWIT_ADDR_PERIOD) begin
			nxt_rdata = {5'h00, period_code_ff};
		end else if (bus.addr == `LWIT_ADDR_MODE) begin
			nxt_rdata = {run_ff, 2'h0, mode_ff == LWIT_MODE_GUARD, 4'h0};
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			bus.rdata  <= 8'h00;
			bus.rvalid <= 1'b0;
		end else begin
			bus.rdata  <= bus.rd ? nxt_rdata : 8'h00;
			bus.rvalid <= bus.rd;
		end
	end

	// Settle status outputs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			settle_busy_out <= 1'b1;
			settle_code_out <= 3'(`LWIT_RST_SETTLE);
		end else begin
			settle_busy_out <= settling_ff;
			settle_code_out <= settle_code_ff;
		end
	end
endmodule : lwit_timer
`default_nettype wire
